// file: rtl/cbd_pkg.sv
/*
 * cbd_pkg: constants, types and helper functions shared by the coded
 * bit demultiplexer and its bit store.
 * assumes: a single clock domain; packet lengths up to K_MAX bits.
 */
package cbd_pkg;

    // sizes of the packet and the bit store
    localparam int KW       = 10;
    localparam int AW       = 12;
    localparam int K_MAX    = 512;
    localparam int MEM_BITS = 5 * K_MAX + 18;

    // code selection threshold on the packet length
    localparam logic [KW-1:0] TURBO_MIN_K = 10'h080;

    // convolutional code: three streams, eight tail periods
    localparam logic [AW-1:0] CONV_TAIL_BITS = 12'h018;
    localparam logic [KW-1:0] CONV_TAIL_LEN  = 10'h008;
    localparam logic [2:0]    CONV_LAST_STRM = 3'h2;

    // turbo code: five streams, eighteen tail bits
    localparam logic [AW-1:0] TURBO_TAIL_BITS = 12'h012;
    localparam logic [2:0]    TURBO_LAST_STRM = 3'h4;
    localparam logic [KW-1:0] TAIL_LEN_INFO   = 10'h006;
    localparam logic [KW-1:0] TAIL_LEN_PAR    = 10'h003;

    // address steps through the arrival-ordered store
    localparam logic [AW-1:0] STEP_CONV  = 12'h003;
    localparam logic [AW-1:0] STEP_TURBO = 12'h005;
    localparam logic [AW-1:0] STEP_TAIL  = 12'h003;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FILL,
        ST_DRAIN
    } cbd_state_t;

    // arrival slot of the stream emitted in output position p
    function automatic logic [2:0] strm_of(input logic turbo,
                                           input logic [2:0] p);
        logic [2:0] s;
        s = p;
        if (turbo) begin
            case (p)
                3'h2:    s = 3'h3;
                3'h3:    s = 3'h2;
                default: s = p;
            endcase
        end
        return s;
    endfunction

    // number of encoder bits expected for a packet
    function automatic logic [AW-1:0] total_bits(input logic turbo,
                                                 input logic [KW-1:0] k);
        logic [AW-1:0] kk;
        kk = AW'(k);
        return turbo ? AW'(kk * 5) + TURBO_TAIL_BITS
                     : AW'(kk * 3) + CONV_TAIL_BITS;
    endfunction

    // offset of a stream's first tail bit within the tail section
    function automatic logic [AW-1:0] tail_base(input logic [2:0] s);
        logic [AW-1:0] b;
        case (s)
            3'h0:    b = 12'h000;
            3'h1:    b = 12'h001;
            3'h2:    b = 12'h002;
            3'h3:    b = 12'h00A;
            default: b = 12'h00B;
        endcase
        return b;
    endfunction

endpackage

// file: rtl/cbd_store_if.sv
/*
 * cbd_store_if: write and read port of the packet bit store.
 * assumes: one clock; the read answer is combinational.
 */
`timescale 1ns/1ps
interface cbd_store_if;
    logic                  wr_en;
    logic [cbd_pkg::AW-1:0] wr_addr;
    logic                  wr_bit;
    logic [cbd_pkg::AW-1:0] rd_addr;
    logic                  rd_bit;

    modport ctrl  (output wr_en, wr_addr, wr_bit, rd_addr, input rd_bit);
    modport store (input wr_en, wr_addr, wr_bit, rd_addr, output rd_bit);
endinterface

// file: rtl/cbd_store.sv
/*
 * cbd_store: flip-flop store holding one packet of encoder bits in
 * arrival order, one bit per address.
 * assumes: addresses beyond the store are never written; they read 0.
 */
`timescale 1ns/1ps
module cbd_store (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // port to the controller
    cbd_store_if.store sp
);
    typedef struct packed {
        logic [cbd_pkg::MEM_BITS-1:0] bits;
    } cbd_store_st_t;

    cbd_store_st_t r_q;
    cbd_store_st_t r_d;

    // write one bit at its arrival index
    always_comb begin
        r_d = r_q;
        if (sp.wr_en && int'(sp.wr_addr) < cbd_pkg::MEM_BITS) begin
            r_d.bits[sp.wr_addr] = sp.wr_bit;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // combinational read, out of range reads zero
    assign sp.rd_bit = (int'(sp.rd_addr) < cbd_pkg::MEM_BITS)
                       ? r_q.bits[sp.rd_addr] : 1'b0;
endmodule

// file: rtl/cbd_demux.sv
/*
 * cbd_demux: coded bit demultiplexer, first stage of channel
 * interleaving. Collects one packet of encoder bits, then emits them
 * regrouped stream by stream towards the bit permuter.
 * assumes: the upstream encoder delivers bits in its own output order;
 * start is a one-cycle pulse carrying the packet length; k <= K_MAX.
 */
`timescale 1ns/1ps
module cbd_demux (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // packet start
    input  wire logic                  start,
    input  wire logic [cbd_pkg::KW-1:0] k_len,
    // encoder bits in
    input  wire logic                  in_valid,
    input  wire logic                  in_bit,
    output logic                       in_ready,
    // reordered bits out
    output logic                       out_valid,
    output logic                       out_bit,
    input  wire logic                  out_ready,
    // status
    output logic                       busy,
    output logic                       turbo,
    output logic                       done
);
    typedef struct packed {
        cbd_pkg::cbd_state_t   st;
        logic [cbd_pkg::KW-1:0] k;
        logic                  turbo;
        logic [cbd_pkg::AW-1:0] wcnt;
        logic [cbd_pkg::AW-1:0] ptr;
        logic [2:0]            p;
        logic [cbd_pkg::KW-1:0] j;
        logic                  tail;
        logic                  fin;
        logic                  ov;
        logic                  ob;
        logic                  done;
        logic [cbd_pkg::AW-1:0] ocnt;
    } cbd_demux_st_t;

    cbd_demux_st_t r_q;
    cbd_demux_st_t r_d;

    cbd_store_if sif ();

    logic                  load;
    logic [2:0]            s_cur;
    logic [cbd_pkg::KW-1:0] len_cur;
    logic                  last_in_strm;
    logic [cbd_pkg::AW-1:0] total;

    cbd_store u_store (
        .mclk (mclk),
        .rst  (rst),
        .sp   (sif)
    );

    // current stream geometry
    always_comb begin
        s_cur = cbd_pkg::strm_of(r_q.turbo, r_q.p);
        total = cbd_pkg::total_bits(r_q.turbo, r_q.k);
        if (!r_q.turbo) begin
            len_cur = r_q.k + cbd_pkg::CONV_TAIL_LEN;
        end else if (!r_q.tail) begin
            len_cur = r_q.k;
        end else if (s_cur == 3'h0) begin
            len_cur = cbd_pkg::TAIL_LEN_INFO;
        end else begin
            len_cur = cbd_pkg::TAIL_LEN_PAR;
        end
        last_in_strm = (r_q.j == len_cur - 10'h001);
        load = (r_q.st == cbd_pkg::ST_DRAIN) && !r_q.fin
               && (!r_q.ov || out_ready);
    end

    // handshake and store port
    assign in_ready    = (r_q.st == cbd_pkg::ST_FILL) && !start;
    assign sif.wr_en   = in_valid && in_ready;
    assign sif.wr_addr = r_q.wcnt;
    assign sif.wr_bit  = in_bit;
    assign sif.rd_addr = r_q.ptr;

    // next state: fill, then walk the store stream by stream
    always_comb begin
        r_d      = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            cbd_pkg::ST_IDLE: begin
                r_d.st = cbd_pkg::ST_IDLE;
            end
            cbd_pkg::ST_FILL: begin
                if (sif.wr_en) begin
                    r_d.wcnt = r_q.wcnt + 12'h001;
                    if (r_q.wcnt == total - 12'h001) begin
                        r_d.st   = cbd_pkg::ST_DRAIN;
                        r_d.ptr  = '0;
                        r_d.p    = '0;
                        r_d.j    = '0;
                        r_d.tail = 1'b0;
                        r_d.fin  = 1'b0;
                        r_d.ocnt = '0;
                    end
                end
            end
            cbd_pkg::ST_DRAIN: begin
                if (r_q.ov && out_ready) begin
                    r_d.ov   = 1'b0;
                    r_d.ocnt = r_q.ocnt + 12'h001;
                    if (r_q.fin) begin
                        r_d.st   = cbd_pkg::ST_IDLE;
                        r_d.done = 1'b1;
                    end
                end
                if (load) begin
                    r_d.ov = 1'b1;
                    r_d.ob = sif.rd_bit;
                    if (!last_in_strm) begin
                        r_d.j = r_q.j + 10'h001;
                        if (!r_q.turbo) begin
                            r_d.ptr = r_q.ptr + cbd_pkg::STEP_CONV;
                        end else if (r_q.tail) begin
                            r_d.ptr = r_q.ptr + cbd_pkg::STEP_TAIL;
                        end else begin
                            r_d.ptr = r_q.ptr + cbd_pkg::STEP_TURBO;
                        end
                    end else if (r_q.turbo && !r_q.tail) begin
                        // jump to this stream's first tail bit
                        r_d.tail = 1'b1;
                        r_d.j    = '0;
                        r_d.ptr  = cbd_pkg::AW'(12'(r_q.k) * 5)
                                   + cbd_pkg::tail_base(s_cur);
                    end else if (r_q.p == (r_q.turbo
                                 ? cbd_pkg::TURBO_LAST_STRM
                                 : cbd_pkg::CONV_LAST_STRM)) begin
                        r_d.fin = 1'b1;
                    end else begin
                        // next stream in output order
                        r_d.p    = r_q.p + 3'h1;
                        r_d.j    = '0;
                        r_d.tail = 1'b0;
                        r_d.ptr  = cbd_pkg::AW'(cbd_pkg::strm_of(
                                   r_q.turbo, r_q.p + 3'h1));
                    end
                end
            end
            default: begin
                r_d.st = cbd_pkg::ST_IDLE;
            end
        endcase
        // a start pulse restarts the packet from any state
        if (start) begin
            r_d.st    = cbd_pkg::ST_FILL;
            r_d.k     = k_len;
            r_d.turbo = (k_len > cbd_pkg::TURBO_MIN_K);
            r_d.wcnt  = '0;
            r_d.ov    = 1'b0;
            r_d.fin   = 1'b0;
            r_d.done  = 1'b0;
            r_d.ocnt  = '0;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs from the state register
    assign out_valid = r_q.ov;
    assign out_bit   = r_q.ob;
    assign busy      = (r_q.st != cbd_pkg::ST_IDLE);
    assign turbo     = r_q.turbo;
    assign done      = r_q.done;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_fill_no_out: assert property (
        (r_q.st == cbd_pkg::ST_FILL) |-> !out_valid && !load)
        else $error("output active while collecting the packet");

    a_conv_addr_order: assert property (
        (load && !r_q.turbo) |->
        int'(r_q.ptr) == 3 * int'(r_q.j) + int'(r_q.p))
        else $error("convolutional read address wrong");

    a_turbo_data_addr: assert property (
        (load && r_q.turbo && !r_q.tail) |->
        int'(r_q.ptr) == 5 * int'(r_q.j) + int'(s_cur))
        else $error("turbo data read address wrong");

    a_tail_info: assert property (
        (load && r_q.turbo && r_q.tail && r_q.p == 3'h0) |->
        int'(r_q.ptr) == 5 * int'(r_q.k) + 3 * int'(r_q.j))
        else $error("information tail address wrong");

    a_tail_parity_one: assert property (
        (load && r_q.turbo && r_q.tail && (r_q.p == 3'h1 || r_q.p == 3'h3))
        |-> int'(r_q.ptr) == 5 * int'(r_q.k) + 3 * int'(r_q.j)
            + ((r_q.p == 3'h1) ? 1 : 2))
        else $error("first encoder parity tail address wrong");

    a_tail_parity_two: assert property (
        (load && r_q.turbo && r_q.tail && (r_q.p == 3'h2 || r_q.p == 3'h4))
        |-> int'(r_q.ptr) == 5 * int'(r_q.k) + 3 * int'(r_q.j)
            + ((r_q.p == 3'h2) ? 10 : 11))
        else $error("second encoder parity tail address wrong");

    a_turbo_stream_order: assert property (
        (load && r_q.turbo && !r_q.tail && r_q.p == 3'h2) |->
        (int'(r_q.ptr) % 5) == 3)
        else $error("second encoder parity a not third");

    a_code_select: assert property (
        start |=> r_q.turbo == (int'($past(k_len)) > 128))
        else $error("code selection does not follow packet length");

    a_done_count: assert property (
        done |-> r_q.ocnt == total && !busy && !out_valid)
        else $error("completion before every bit was emitted");
endmodule

// file: tb/cbd_enc_model.sv
/*
 * cbd_enc_model: upstream encoder stand-in streaming one packet of bits.
 * assumes: go is a one-cycle pulse given with the block's start pulse.
 */
`timescale 1ns/1ps
module cbd_enc_model (
    // clock
    input  wire logic        mclk,
    // control from the bench
    input  wire logic        go,
    input  wire logic [11:0] n_bits,
    input  wire logic        slow,
    // encoder bit stream
    output logic             in_valid,
    output logic             in_bit,
    input  wire logic        in_ready
);
    int   cnt;
    int   left;
    int   nxt;
    logic ph;

    // value carried by encoder output bit number i
    function automatic logic pat(input int i);
        logic [15:0] h;
        h = 16'(i * 40503);
        return h[11] ^ h[5] ^ h[0];
    endfunction

    // quiet line at time zero
    initial begin
        in_valid = 1'b0;
        in_bit = 1'b0;
        ph = 1'b0;
    end

    // bits held until taken; idle line toggles every cycle
    always @(posedge mclk) begin
        ph <= ~ph;
        if (go) begin
            cnt <= 0;
            left <= int'(n_bits);
            in_valid <= 1'b0;
            in_bit <= ~in_bit;
        end else if (!in_valid || in_ready) begin
            nxt = in_valid ? left - 1 : left;
            if (in_valid) begin
                cnt <= cnt + 1;
                left <= left - 1;
            end
            if (nxt > 0 && (!slow || ph)) begin
                in_valid <= 1'b1;
                in_bit <= pat(in_valid ? cnt + 1 : cnt);
            end else begin
                in_valid <= 1'b0;
                in_bit <= ~in_bit;
            end
        end
    end
endmodule

// file: tb/testbench.sv
/*
 * testbench: self-checking bench for the coded bit demultiplexer.
 * assumes: cbd_enc_model feeds the input; the bench drains the output.
 */
`timescale 1ns/1ps
module testbench;
    logic                   mclk;
    logic                   rst;
    logic                   start;
    logic                   go;
    logic                   slow;
    logic                   out_ready;
    logic [cbd_pkg::KW-1:0] k_len;
    logic [11:0]            n_bits;
    logic                   in_valid;
    logic                   in_bit;
    logic                   in_ready;
    logic                   out_valid;
    logic                   out_bit;
    logic                   busy;
    logic                   turbo;
    logic                   done;
    int                     n_mismatch;
    int                     checked;
    int                     idxq[$];

    cbd_demux uut (.mclk(mclk), .rst(rst), .start(start), .k_len(k_len),
        .in_valid(in_valid), .in_bit(in_bit), .in_ready(in_ready),
        .out_valid(out_valid), .out_bit(out_bit), .out_ready(out_ready),
        .busy(busy), .turbo(turbo), .done(done));

    cbd_enc_model u_src (.mclk(mclk), .go(go), .n_bits(n_bits),
        .slow(slow), .in_valid(in_valid), .in_bit(in_bit),
        .in_ready(in_ready));

    // clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic seen, input logic exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s: saw %b want %b", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // encoder bit index of each output position, in output order
    task automatic build(input int k);
        int ord[5] = '{0, 1, 3, 2, 4};
        int tb[5] = '{0, 1, 2, 10, 11};
        idxq.delete();
        if (k > 128) begin
            foreach (ord[o]) begin
                for (int j = 0; j < k; j++) idxq.push_back(5 * j + ord[o]);
                for (int m = 0; m < (ord[o] == 0 ? 6 : 3); m++)
                    idxq.push_back(5 * k + tb[ord[o]] + 3 * m);
            end
        end else begin
            for (int s = 0; s < 3; s++)
                for (int j = 0; j < k + 8; j++) idxq.push_back(3 * j + s);
        end
    endtask

    // one whole packet in, all reordered bits out and compared
    task automatic run_pkt(input int k, input logic sl, input logic stall);
        int   p;
        int   t;
        logic e;
        build(k);
        @(posedge mclk);
        start <= 1'b1;
        go <= 1'b1;
        slow <= sl;
        k_len <= 10'(k);
        n_bits <= 12'(idxq.size());
        #1 chk(in_ready, 1'b0, "ready in start cycle");
        @(posedge mclk);
        start <= 1'b0;
        go <= 1'b0;
        p = 0;
        t = 0;
        while (p < idxq.size() && t < 20000) begin
            @(posedge mclk);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                e = u_src.pat(idxq[p]);
                if (p == 0) chk(turbo, 1'(k > 128), "code choice");
                if (k > 128) begin
                    chk(out_bit, e, "bit");
                end else begin
                    chk(out_bit, e, "bit");
                end
                p++;
            end
            out_ready <= !stall || (t % 3 != 0);
            t++;
        end
        chk(1'(p == idxq.size()), 1'b1, "output count");
        @(posedge mclk);
        out_ready <= 1'b1;
        chk(done, 1'b1, "done after last bit");
        chk(busy, 1'b0, "idle after last bit");
    endtask

    task automatic t_conv_min();
        run_pkt(0, 1'b0, 1'b1);
    endtask

    task automatic t_conv_max();
        run_pkt(128, 1'b1, 1'b0);
    endtask

    task automatic t_turbo_min();
        run_pkt(129, 1'b1, 1'b1);
    endtask

    task automatic t_turbo_max();
        run_pkt(512, 1'b0, 1'b1);
    endtask

    // restart in mid-fill drops the old packet
    task automatic t_abort();
        @(posedge mclk);
        start <= 1'b1;
        go <= 1'b1;
        k_len <= 10'h0C8;
        n_bits <= 12'h3FA;
        @(posedge mclk);
        start <= 1'b0;
        go <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(busy, 1'b1, "busy in fill");
        chk(in_ready, 1'b1, "ready through fill");
        run_pkt(5, 1'b1, 1'b1);
    endtask

    // watchdog
    initial begin
        #150000;
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        checked = 0;
        rst = 1'b1;
        start = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        out_ready = 1'b1;
        k_len = '0;
        n_bits = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        chk(out_valid, 1'b0, "out_valid in reset");
        chk(done, 1'b0, "done in reset");
        t_conv_min();
        t_conv_max();
        t_turbo_min();
        t_abort();
        t_turbo_max();
        close_out();
    end
endmodule
